//--- rtl/ioc_irq_orient.sv
// orientation detector configuration, interrupt status and interrupt pin drive behind an APB slave
// Behaviour
// - primary pin polarity from setup bit 7
// - bit 6 selects unlatched timed or latched
// - secondary pin polarity from setup bit 5
// - bit 4: any read clears flags
// - secondary pin push-pull or open-drain, bit 2
// - primary pin push-pull or open-drain, bit 0
// - unlatched pin ends after limit plus one 512Hz ticks
// - up-down changes interrupt only when enabled
// - six-bit squared tangent angle threshold
// - mode 01: angle or magnitude blocking
// - mode 10: adds slope above limit
// - mode 11: double slope, 100ms stability
// - mode field picks symmetric or asymmetric
// - magnitude limit from two byte registers
// - slope limit from two byte registers
// - hysteresis from two byte registers
// - orientation interrupt needs enable bit 0
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module ioc_irq_orient #(
    parameter int TICK_CYCLES = `IOC_TICK_CYCLES,
    parameter int STABLE_CYCLES = `IOC_STABLE_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire ioc_pkg::ioc_accel_s sample,
    output logic irq,
    output ioc_pkg::ioc_pin_s primary_irq_pin,
    output ioc_pkg::ioc_pin_s secondary_irq_pin
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam logic [`IOC_TICK_W-1:0] TICK_LAST = `IOC_TICK_W'(TICK_CYCLES - 1);
    localparam logic [`IOC_STAB_W-1:0] STABLE_LAST = `IOC_STAB_W'(STABLE_CYCLES - 1);
    localparam ioc_pkg::ioc_state_s ST_RST = '{pin_setup: `IOC_RST_PIN_SETUP, default: '0};

    // all state in one register
    ioc_pkg::ioc_state_s s_r;
    ioc_pkg::ioc_state_s s_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // unsigned, so full-scale negative still fits
    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        mag16 = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // extra bit for opposite full-scale readings
    function automatic logic [16:0] dist17(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [16:0] d;
        d = 17'(a) - 17'(b);
        dist17 = d[16] ? 17'(-d) : 17'(d);
    endfunction

    // open-drain releases the wire for a high level and pulls it low otherwise
    function automatic ioc_pkg::ioc_pin_s drive(input logic act, input logic low, input logic pp);
        logic lvl;
        ioc_pkg::ioc_pin_s p;
        lvl = act ^ low;
        p.out = pp ? lvl : 1'b0;
        p.oe_n = pp ? 1'b0 : lvl;
        drive = p;
    endfunction

    // ----------------------------------------------------------------
    // orientation detector terms
    // ----------------------------------------------------------------
    logic [15:0] ax, ay, az;
    logic [16:0] bias_x, bias_y;
    logic [17:0] lim_x, lim_y;
    logic [32:0] planar_sq;
    logic [39:0] tilt_lhs, tilt_rhs;
    logic theta_blk, mag_blk, slope_blk, stab_blk, blocked;
    logic [16:0] slope_lim_eff;
    logic landscape;
    ioc_pkg::ioc_orient_s cand_now;

    always_comb begin
        ax = mag16(sample.x);
        ay = mag16(sample.y);
        az = mag16(sample.z);

        // asymmetric modes scale one axis by 1.5
        unique case (s_r.block_setup[1:0])
            2'b01: begin
                bias_x = {1'b0, ax};
                bias_y = 17'({1'b0, ay}) + 17'(ay >> 1);
            end
            2'b10: begin
                bias_x = 17'({1'b0, ax}) + 17'(ax >> 1);
                bias_y = {1'b0, ay};
            end
            default: begin
                bias_x = {1'b0, ax};
                bias_y = {1'b0, ay};
            end
        endcase

        // hysteresis widens only the way out
        lim_x = 18'(bias_x) + 18'(s_r.hyst);
        lim_y = 18'(bias_y) + 18'(s_r.hyst);

        if (s_r.orient.plane[1]) begin
            landscape = !(18'(bias_y) > lim_x);
        end else begin
            landscape = 18'(bias_x) > lim_y;
        end

        cand_now.face_down = sample.z[15];
        if (landscape) begin
            cand_now.plane = sample.x[15] ? ioc_pkg::IOC_LANDSCAPE_RIGHT : ioc_pkg::IOC_LANDSCAPE_LEFT;
        end else begin
            cand_now.plane = sample.y[15] ? ioc_pkg::IOC_PORTRAIT_DOWN : ioc_pkg::IOC_PORTRAIT_UP;
        end

        // near-flat device: the planar part is too small against the vertical one
        planar_sq = 33'(ax * ax) + 33'(ay * ay);
        tilt_lhs = 40'(planar_sq) << 3;
        tilt_rhs = 40'(s_r.angle_setup[5:0]) * 40'(az * az);
        theta_blk = tilt_lhs < tilt_rhs;

        mag_blk = (ax > s_r.mag_lim) || (ay > s_r.mag_lim) || (az > s_r.mag_lim);

        slope_lim_eff = (s_r.block_setup[3:2] == 2'b11) ? {s_r.slope_lim, 1'b0} : {1'b0, s_r.slope_lim};
        slope_blk = s_r.prev_ok && ((dist17(sample.x, s_r.prev.x) > slope_lim_eff)
                    || (dist17(sample.y, s_r.prev.y) > slope_lim_eff)
                    || (dist17(sample.z, s_r.prev.z) > slope_lim_eff));

        stab_blk = (cand_now != s_r.cand) || (s_r.stab_cnt < STABLE_LAST);
        unique case (s_r.block_setup[3:2])
            2'b00: blocked = 1'b0;
            2'b01: blocked = theta_blk || mag_blk;
            2'b10: blocked = theta_blk || slope_blk || mag_blk;
            2'b11: blocked = theta_blk || slope_blk || mag_blk || stab_blk;
        endcase
    end

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    // index is byte address over four
    logic [7:0] idx;
    logic mapped, setup_ph, access_ph, wr_lo;
    logic [7:0] rd_byte, wb;
    logic [1:0] stat_set, stat_clr;
    logic plane_chg, updown_chg, new_evt, pend, tick;

    always_comb begin
        idx = paddr[9:2];
        setup_ph = psel && !penable;
        access_ph = psel && penable && s_r.pready;
        wr_lo = access_ph && pwrite && pstrb[0] && !s_r.pslverr;
        wb = pwdata[7:0];

        mapped = 1'b1;

        unique case (idx)
            `IOC_IDX_INT_EN: rd_byte = s_r.int_en;
            `IOC_IDX_PIN_SETUP: rd_byte = s_r.pin_setup;
            `IOC_IDX_HOLD_LIMIT: rd_byte = s_r.hold_lim;
            `IOC_IDX_ANGLE_SETUP: rd_byte = s_r.angle_setup;
            `IOC_IDX_BLOCK_SETUP: rd_byte = s_r.block_setup;
            `IOC_IDX_MAG_LO: rd_byte = s_r.mag_lim[7:0];
            `IOC_IDX_MAG_HI: rd_byte = s_r.mag_lim[15:8];
            `IOC_IDX_SLOPE_LO: rd_byte = s_r.slope_lim[7:0];
            `IOC_IDX_SLOPE_HI: rd_byte = s_r.slope_lim[15:8];
            `IOC_IDX_HYST_LO: rd_byte = s_r.hyst[7:0];
            `IOC_IDX_HYST_HI: rd_byte = s_r.hyst[15:8];
            `IOC_IDX_STATUS: rd_byte = {6'h00, s_r.status};
            `IOC_IDX_MASK: rd_byte = {6'h00, s_r.mask};
            `IOC_IDX_ORIENT: rd_byte = {5'h00, s_r.orient};
            default: begin
                rd_byte = 8'h00;
                mapped = 1'b0;
            end
        endcase

        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        stat_set = 2'b00;
        stat_clr = 2'b00;
        plane_chg = 1'b0;
        updown_chg = 1'b0;

        // apb: no wait state, ready and data registered in the setup cycle so the answer comes from flip-flops
        s_nxt.pready = setup_ph;

        if (setup_ph) begin
            s_nxt.pslverr = !mapped;
            s_nxt.prdata = (!pwrite && mapped) ? {24'h000000, rd_byte} : 32'h00000000;
            // only flags already visible to this read may be cleared by it
            if (!pwrite && mapped && (s_r.pin_setup[`IOC_PIN_ANY_READ] || idx == `IOC_IDX_STATUS)) begin
                s_nxt.rclr = s_r.status;
            end else begin
                s_nxt.rclr = 2'b00;
            end
        end

        // read clears land with the data
        if (access_ph && !pwrite && !s_r.pin_setup[`IOC_PIN_UNLATCH]) begin
            stat_clr = s_r.rclr;
        end else if (access_ph && !pwrite && s_r.pin_setup[`IOC_PIN_ANY_READ]) begin
            stat_clr = s_r.rclr;
        end

        // low lane strobe off: answered, ignored
        if (wr_lo) begin
            unique case (idx)
                `IOC_IDX_INT_EN: s_nxt.int_en = wb;
                `IOC_IDX_PIN_SETUP: s_nxt.pin_setup = wb & `IOC_PIN_SETUP_MASK;
                `IOC_IDX_HOLD_LIMIT: s_nxt.hold_lim = wb;
                `IOC_IDX_ANGLE_SETUP: s_nxt.angle_setup = wb & `IOC_ANGLE_MASK;
                `IOC_IDX_BLOCK_SETUP: s_nxt.block_setup = wb & `IOC_BLOCK_MASK;
                `IOC_IDX_MAG_LO: s_nxt.mag_lim[7:0] = wb;
                `IOC_IDX_MAG_HI: s_nxt.mag_lim[15:8] = wb;
                `IOC_IDX_SLOPE_LO: s_nxt.slope_lim[7:0] = wb;
                `IOC_IDX_SLOPE_HI: s_nxt.slope_lim[15:8] = wb;
                `IOC_IDX_HYST_LO: s_nxt.hyst[7:0] = wb;
                `IOC_IDX_HYST_HI: s_nxt.hyst[15:8] = wb;
                `IOC_IDX_STATUS: stat_clr = stat_clr | wb[1:0];
                `IOC_IDX_MASK: s_nxt.mask = wb[1:0];
                default: ;
            endcase
        end

        // stability timer runs on mclk, restarted whenever the candidate moves
        if (s_r.stab_cnt != STABLE_LAST) begin
            s_nxt.stab_cnt = s_r.stab_cnt + `IOC_STAB_W'(1);
        end

        // prev kept even when blocked
        if (sample_valid) begin
            s_nxt.prev = sample;
            s_nxt.prev_ok = 1'b1;
            s_nxt.cand = cand_now;
            if (cand_now != s_r.cand) begin
                s_nxt.stab_cnt = '0;
            end

            if (!blocked) begin
                s_nxt.orient = cand_now;
                plane_chg = cand_now.plane != s_r.orient.plane;
                updown_chg = (cand_now.face_down != s_r.orient.face_down)
                             && s_r.angle_setup[`IOC_ANGLE_UPDOWN];
            end
        end

        // disabled detector still tracks
        if (s_r.int_en[`IOC_INT_EN_ORIENT]) begin
            stat_set[`IOC_STAT_PLANE] = plane_chg;
            stat_set[`IOC_STAT_UPDOWN] = updown_chg;
        end

        // a flag set in the clearing cycle survives
        s_nxt.status = (s_r.status & ~stat_clr) | stat_set;

        // only a new unmasked flag restarts a pulse
        new_evt = |(stat_set & s_r.mask);
        pend = |(s_nxt.status & s_r.mask);
        s_nxt.irq = pend;

        // pin activity: latched follows the flags, unlatched is a timed pulse
        tick = s_r.tick_cnt == TICK_LAST;

        // one tick beyond the limit before release
        if (!s_r.pin_setup[`IOC_PIN_UNLATCH]) begin
            s_nxt.active = pend;
            s_nxt.hold_cnt = '0;
            s_nxt.tick_cnt = '0;
        end else if (new_evt) begin
            s_nxt.active = 1'b1;
            s_nxt.hold_cnt = '0;
            s_nxt.tick_cnt = '0;
        end else if (s_r.active) begin
            s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + `IOC_TICK_W'(1);
            if (tick) begin
                s_nxt.hold_cnt = s_r.hold_cnt + 9'h001;
            end
            if (s_r.hold_cnt > {1'b0, s_r.hold_lim}) begin
                s_nxt.active = 1'b0;
                s_nxt.tick_cnt = '0;
            end
        end


        // pins follow next state, in step with irq
        s_nxt.pri_pin = drive(s_nxt.active, s_nxt.pin_setup[`IOC_PIN_PRI_LOW],
                              s_nxt.pin_setup[`IOC_PIN_PRI_PP]);
        s_nxt.sec_pin = drive(s_nxt.active, s_nxt.pin_setup[`IOC_PIN_SEC_LOW],
                              s_nxt.pin_setup[`IOC_PIN_SEC_PP]);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // outputs straight from flops
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;
    assign primary_irq_pin = s_r.pri_pin;
    assign secondary_irq_pin = s_r.sec_pin;

endmodule // ioc_irq_orient

//--- rtl/ioc_regs.svh
// register indexes, field positions, reset values and timing figures of the orientation interrupt block
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IOC_IDX_INT_EN 8'h40
`define IOC_IDX_PIN_SETUP 8'h44
`define IOC_IDX_HOLD_LIMIT 8'h45
`define IOC_IDX_ANGLE_SETUP 8'h46
`define IOC_IDX_BLOCK_SETUP 8'h47
`define IOC_IDX_MAG_LO 8'h48
`define IOC_IDX_MAG_HI 8'h49
`define IOC_IDX_SLOPE_LO 8'h4a
`define IOC_IDX_SLOPE_HI 8'h4b
`define IOC_IDX_HYST_LO 8'h4c
`define IOC_IDX_HYST_HI 8'h4d
`define IOC_IDX_STATUS 8'h60
`define IOC_IDX_MASK 8'h61
`define IOC_IDX_ORIENT 8'h62

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define IOC_PIN_PRI_LOW 7
`define IOC_PIN_UNLATCH 6
`define IOC_PIN_SEC_LOW 5
`define IOC_PIN_ANY_READ 4
`define IOC_PIN_SEC_PP 2
`define IOC_PIN_PRI_PP 0
`define IOC_PIN_SETUP_MASK 8'hf5
`define IOC_ANGLE_UPDOWN 6
`define IOC_ANGLE_MASK 8'h7f
`define IOC_BLOCK_MASK 8'h0f
`define IOC_INT_EN_ORIENT 0
`define IOC_STAT_PLANE 0
`define IOC_STAT_UPDOWN 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IOC_RST_PIN_SETUP 8'h05

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IOC_MCLK_HZ 25000000
`define IOC_TICK_HZ 512
`define IOC_STABLE_MS 100
`define IOC_TICK_CYCLES (`IOC_MCLK_HZ / `IOC_TICK_HZ)
`define IOC_STABLE_CYCLES ((`IOC_MCLK_HZ / 1000) * `IOC_STABLE_MS)
`define IOC_TICK_W 16
`define IOC_STAB_W 22

`endif

//--- rtl/ioc_pkg.sv
// types shared by the orientation interrupt block
`include "ioc_regs.svh"
package ioc_pkg;

    // ----------------------------------------------------------------
    // orientation result
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IOC_PORTRAIT_UP = 2'b00,
        IOC_PORTRAIT_DOWN = 2'b01,
        IOC_LANDSCAPE_LEFT = 2'b10,
        IOC_LANDSCAPE_RIGHT = 2'b11
    } ioc_plane_e;

    typedef struct packed {
        logic face_down;
        ioc_plane_e plane;
    } ioc_orient_s;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } ioc_accel_s;

    typedef struct packed {
        logic out;
        logic oe_n;
    } ioc_pin_s;

    // ----------------------------------------------------------------
    // whole block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] int_en;
        logic [7:0] pin_setup;
        logic [7:0] hold_lim;
        logic [7:0] angle_setup;
        logic [7:0] block_setup;
        logic [15:0] mag_lim;
        logic [15:0] slope_lim;
        logic [15:0] hyst;
        logic [1:0] status;
        logic [1:0] mask;
        logic [1:0] rclr;
        ioc_orient_s orient;
        ioc_orient_s cand;
        ioc_accel_s prev;
        logic prev_ok;
        logic [`IOC_STAB_W-1:0] stab_cnt;
        logic [`IOC_TICK_W-1:0] tick_cnt;
        logic [8:0] hold_cnt;
        logic active;
        logic irq;
        ioc_pin_s pri_pin;
        ioc_pin_s sec_pin;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ioc_state_s;

endpackage

//--- tb/ioc_host_model.sv
// host side model that resolves both interrupt lines as the host samples them
`timescale 1ns/1ps
module ioc_host_model (
    input wire ioc_pkg::ioc_pin_s pri_pin,
    input wire ioc_pkg::ioc_pin_s sec_pin,
    output logic pri_wire,
    output logic sec_wire
);
    // a released line goes to the board pull-up, never to the last driven value
    assign pri_wire = pri_pin.oe_n ? 1'b1 : pri_pin.out;
    assign sec_wire = sec_pin.oe_n ? 1'b1 : sec_pin.out;
endmodule // ioc_host_model

//--- tb/ioc_irq_orient_checker.sv
// port-level assertions for the orientation interrupt block
`timescale 1ns/1ps
`include "ioc_regs.svh"
module ioc_irq_orient_checker #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_valid,
    input wire logic irq,
    input wire ioc_pkg::ioc_pin_s primary_irq_pin,
    input wire ioc_pkg::ioc_pin_s secondary_irq_pin
);
    logic [7:0] setup_r;
    logic [7:0] setup_d_r;
    logic [7:0] hold_r;
    logic [15:0] act_cnt_r;
    logic wr_hit;
    logic cfg_ok;
    function automatic ioc_pkg::ioc_pin_s pin_exp(logic act, logic low, logic pp);
        logic lv;
        lv = act ^ low;
        pin_exp = pp ? {lv, 1'b0} : {1'b0, lv};
    endfunction
    function automatic logic pin_act(ioc_pkg::ioc_pin_s p, logic low, logic pp);
        pin_act = (pp ? p.out : p.oe_n) ^ low;
    endfunction
    assign wr_hit = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    // pins may follow a setup write one cycle late, so only judge a settled setup
    assign cfg_ok = setup_r == setup_d_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            setup_r <= `IOC_RST_PIN_SETUP;
            setup_d_r <= `IOC_RST_PIN_SETUP;
            hold_r <= 8'h00;
            act_cnt_r <= 16'h0000;
        end else begin
            if (wr_hit && paddr == {`IOC_IDX_PIN_SETUP, 2'b00}) setup_r <= pwdata[7:0] & `IOC_PIN_SETUP_MASK;
            if (wr_hit && paddr == {`IOC_IDX_HOLD_LIMIT, 2'b00}) hold_r <= pwdata[7:0];
            setup_d_r <= setup_r;
            act_cnt_r <= (setup_r[6] && pin_act(primary_irq_pin, setup_r[7], setup_r[0])) ? act_cnt_r + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_bus_answer: assert property (s_setup |=> s_access) else $error("no answer after setup");
    a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
    a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
    a_irq_rise: assert property ($rose(irq) |-> $past(sample_valid) || $past(pready) || $past(pready, 2))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2))
        else $error("irq fell without bus access");
    a_pulse_bound: assert property (act_cnt_r <= (hold_r + 3) * TICK_CYCLES)
        else $error("timed pulse too long");
    a_pri_pin: assert property (!setup_r[6] && cfg_ok |-> primary_irq_pin == pin_exp(irq, setup_r[7], setup_r[0]))
        else $error("primary pin level wrong");
    a_sec_pin: assert property (!setup_r[6] && cfg_ok |-> secondary_irq_pin == pin_exp(irq, setup_r[5], setup_r[2]))
        else $error("secondary pin level wrong");
    a_pulse_start: assert property (setup_r[6] && cfg_ok && $rose(irq) |-> pin_act(primary_irq_pin, setup_r[7], setup_r[0]))
        else $error("timed pulse did not start");
endmodule // ioc_irq_orient_checker

bind ioc_irq_orient ioc_irq_orient_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.mclk(mclk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .irq(irq),
    .primary_irq_pin(primary_irq_pin), .secondary_irq_pin(secondary_irq_pin));

//--- tb/tb_top.sv
// self-checking bench for the orientation interrupt block
`timescale 1ns/1ps
`include "ioc_regs.svh"
module tb_top;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic sample_valid = 1'b0;
    ioc_pkg::ioc_accel_s sample = '0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, pri_wire, sec_wire, err;
    ioc_pkg::ioc_pin_s pri_pin, sec_pin;
    logic [31:0] rd;
    int error_cnt = 0;
    int checked = 0;
    always #20 mclk = ~mclk;
    // short tick and stability counts keep the run brief
    ioc_irq_orient #(.TICK_CYCLES(4), .STABLE_CYCLES(8)) i_dut (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .sample(sample), .irq(irq),
        .primary_irq_pin(pri_pin), .secondary_irq_pin(sec_pin));
    ioc_host_model i_host (.pri_pin(pri_pin), .sec_pin(sec_pin), .pri_wire(pri_wire), .sec_wire(sec_wire));
    // ----------------------------------------------------------------
    // bus and sample tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [1:0] lo);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, lo};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 2'b00);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
        apb(1'b0, idx, 8'h00, 2'b00);
        cmp(rd & m, exp);
        cmp(err, 1'b0);
    endtask
    task automatic send(input logic signed [15:0] z);
        @(posedge mclk);
        sample <= {16'sh0, 16'sh0, z};
        sample_valid <= 1'b1;
        @(posedge mclk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] idx [14] = '{`IOC_IDX_INT_EN, `IOC_IDX_PIN_SETUP, `IOC_IDX_HOLD_LIMIT, `IOC_IDX_ANGLE_SETUP,
            `IOC_IDX_BLOCK_SETUP, `IOC_IDX_MAG_LO, `IOC_IDX_MAG_HI, `IOC_IDX_SLOPE_LO, `IOC_IDX_SLOPE_HI,
            `IOC_IDX_HYST_LO, `IOC_IDX_HYST_HI, `IOC_IDX_STATUS, `IOC_IDX_MASK, `IOC_IDX_ORIENT};
        logic [7:0] msk [11] = '{8'h00, 8'hf5, 8'hff, 8'h7f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
        for (int i = 0; i < 14; i++) rd_chk(idx[i], (i == 1) ? 32'h05 : 32'h0);
        for (int i = 1; i < 11; i++) begin
            wr(idx[i], 8'hff);
            rd_chk(idx[i], {24'h0, msk[i]});
            wr(idx[i], (i == 1) ? 8'h05 : 8'h00);
        end
        apb(1'b0, 8'h10, 8'h00, 2'b00);
        cmp(err, 1'b1);
        apb(1'b0, `IOC_IDX_HOLD_LIMIT, 8'h00, 2'b10);
        cmp(err, 1'b1);
        pstrb <= 4'he;
        wr(`IOC_IDX_HOLD_LIMIT, 8'h5a);
        pstrb <= 4'hf;
        rd_chk(`IOC_IDX_HOLD_LIMIT, 32'h0);
    endtask
    task automatic t_latched();
        wr(`IOC_IDX_INT_EN, 8'h01);
        wr(`IOC_IDX_ANGLE_SETUP, 8'h40);
        wr(`IOC_IDX_MASK, 8'h02);
        send(-16'sd8000);
        cmp(irq, 1'b1);
        cmp(pri_pin, 2'b10);
        repeat (30) @(posedge mclk);
        #1 cmp(irq, 1'b1);
        rd_chk(`IOC_IDX_ORIENT, 32'h4, 32'h4);
        rd_chk(`IOC_IDX_STATUS, 32'h2, 32'h2);
        rd_chk(`IOC_IDX_STATUS, 32'h0, 32'h2);
        #1 cmp(irq, 1'b0);
    endtask
    task automatic t_pins();
        wr(`IOC_IDX_PIN_SETUP, 8'hb1);
        send(16'sd8000);
        cmp(pri_pin, 2'b00);
        cmp(sec_pin, 2'b00);
        cmp(sec_wire, 1'b0);
        rd_chk(`IOC_IDX_HOLD_LIMIT, 32'h0);
        rd_chk(`IOC_IDX_STATUS, 32'h0, 32'h2);
        #1 cmp(pri_pin, 2'b10);
        cmp(sec_pin, 2'b01);
        cmp(sec_wire, 1'b1);
        wr(`IOC_IDX_PIN_SETUP, 8'h05);
    endtask
    task automatic t_disable();
        wr(`IOC_IDX_INT_EN, 8'h00);
        send(-16'sd8000);
        cmp(irq, 1'b0);
        rd_chk(`IOC_IDX_STATUS, 32'h0, 32'h2);
        wr(`IOC_IDX_INT_EN, 8'h01);
        wr(`IOC_IDX_ANGLE_SETUP, 8'h00);
        send(16'sd8000);
        cmp(irq, 1'b0);
        rd_chk(`IOC_IDX_STATUS, 32'h0, 32'h2);
        wr(`IOC_IDX_ANGLE_SETUP, 8'h40);
    endtask
    task automatic t_pulse();
        wr(`IOC_IDX_HOLD_LIMIT, 8'h02);
        wr(`IOC_IDX_PIN_SETUP, 8'h45);
        send(-16'sd8000);
        repeat (6) @(posedge mclk);
        #1 cmp(pri_pin, 2'b10);
        repeat (34) @(posedge mclk);
        #1 cmp(pri_pin, 2'b00);
        cmp(irq, 1'b1);
        wr(`IOC_IDX_STATUS, 8'h02);
        send(16'sd8000);
        cmp(pri_pin, 2'b10);
        wr(`IOC_IDX_STATUS, 8'h02);
        wr(`IOC_IDX_PIN_SETUP, 8'h05);
    endtask
    task automatic t_block();
        wr(`IOC_IDX_BLOCK_SETUP, 8'h04);
        wr(`IOC_IDX_MAG_LO, 8'h64);
        send(-16'sd8000);
        cmp(irq, 1'b0);
        rd_chk(`IOC_IDX_ORIENT, 32'h0, 32'h4);
        wr(`IOC_IDX_MAG_LO, 8'hff);
        wr(`IOC_IDX_MAG_HI, 8'h7f);
        send(-16'sd8000);
        cmp(irq, 1'b1);
        rd_chk(`IOC_IDX_STATUS, 32'h2, 32'h2);
        wr(`IOC_IDX_BLOCK_SETUP, 8'h08);
        wr(`IOC_IDX_SLOPE_LO, 8'h64);
        send(16'sd8000);
        cmp(irq, 1'b0);
        wr(`IOC_IDX_SLOPE_LO, 8'hff);
        wr(`IOC_IDX_SLOPE_HI, 8'h7f);
        send(16'sd8000);
        cmp(irq, 1'b1);
    endtask
    task automatic t_stable();
        wr(`IOC_IDX_STATUS, 8'h02);
        wr(`IOC_IDX_BLOCK_SETUP, 8'h0c);
        send(-16'sd8000);
        cmp(irq, 1'b0);
        rd_chk(`IOC_IDX_ORIENT, 32'h0, 32'h4);
        repeat (8) @(posedge mclk);
        send(-16'sd8000);
        cmp(irq, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_latched();
        t_pins();
        t_disable();
        t_pulse();
        t_block();
        t_stable();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        complete_run();
    end
endmodule // tb_top
